// ---- src/decode_array.sv ----
// combinational decode logic array with priority resolution
`include "map_decode_params.svh"

module decode_array
    import map_decode_pkg::*;
#(
    parameter int N_PRI = 8,
    parameter int N_SEC = 4
) (
    // decoded inputs
    input wire logic [15:0] pla_addr_i,
    input wire logic [7:0] page_bits_i,
    input wire logic [7:0] map_i,
    input wire logic rd_i,
    input wire logic fetch_i,
    input wire logic any_strobe_i,
    // window programming
    input wire map_decode_pkg::window_t [N_PRI*3-1:0] pri_win_i,
    input wire map_decode_pkg::window_t [N_SEC*3-1:0] sec_win_i,
    input wire map_decode_pkg::window_t [1:0] ram_win_i,
    input wire map_decode_pkg::window_t cfg_win_i,
    input wire map_decode_pkg::window_t jtag_win_i,
    input wire map_decode_pkg::window_t [1:0] periph_win_i,
    input wire logic [7:0] page_match_i,
    // results
    output map_decode_pkg::selects_t sel_o
);
    import map_decode_pkg::*;

    function automatic logic hit(input window_t w, input logic [15:0] a,
                                 input logic [7:0] pg, input logic [7:0] pm);
        hit = ((a & w.mask) == (w.base & w.mask)) && ((pg & pm) == pm);
    endfunction

    logic [N_PRI-1:0] pri_hit;
    logic [N_SEC-1:0] sec_hit;
    logic ram_hit;
    logic cfg_hit;
    logic [1:0] per_hit;
    logic high_hit;
    logic pri_ok;
    logic sec_ok;
    logic ram_ok;

    always_comb begin
        // up to three product terms per sector select
        for (int i = 0; i < N_PRI; i++) begin
            pri_hit[i] = hit(pri_win_i[3*i], pla_addr_i, page_bits_i, page_match_i)
                       | hit(pri_win_i[3*i+1], pla_addr_i, page_bits_i, page_match_i)
                       | hit(pri_win_i[3*i+2], pla_addr_i, page_bits_i, page_match_i);
        end
        for (int i = 0; i < N_SEC; i++) begin
            sec_hit[i] = hit(sec_win_i[3*i], pla_addr_i, page_bits_i, page_match_i)
                       | hit(sec_win_i[3*i+1], pla_addr_i, page_bits_i, page_match_i)
                       | hit(sec_win_i[3*i+2], pla_addr_i, page_bits_i, page_match_i);
        end
        ram_hit = hit(ram_win_i[0], pla_addr_i, page_bits_i, page_match_i)
                | hit(ram_win_i[1], pla_addr_i, page_bits_i, page_match_i);
        cfg_hit = hit(cfg_win_i, pla_addr_i, 8'h00, 8'h00);
        per_hit[0] = hit(periph_win_i[0], pla_addr_i, 8'h00, 8'h00) & map_i[`MAP_PERIPHERAL_IO_ENABLE_BIT];
        per_hit[1] = hit(periph_win_i[1], pla_addr_i, 8'h00, 8'h00) & map_i[`MAP_PERIPHERAL_IO_ENABLE_BIT];
        high_hit = ram_hit | cfg_hit | (|per_hit);
        // strobe gating by map bits
        pri_ok = (rd_i & map_i[`MAP_PRI_DATA_BIT]) | (fetch_i & map_i[`MAP_PRI_CODE_BIT]);
        sec_ok = (rd_i & map_i[`MAP_SEC_DATA_BIT]) | (fetch_i & map_i[`MAP_SEC_CODE_BIT]);
        ram_ok = rd_i | ~fetch_i | map_i[`MAP_RAM_CODE_BIT];
        sel_o.ram_select = ram_hit & ram_ok & any_strobe_i;
        sel_o.config_select = cfg_hit & any_strobe_i;
        sel_o.periph_selects = per_hit & {2{any_strobe_i}};
        sel_o.jtag_select = hit(jtag_win_i, pla_addr_i, 8'h00, 8'h00);
        // secondary over primary, ram/io/periph over both
        sel_o.secondary_sector_selects = (high_hit | ~sec_ok) ? '0 : sec_hit;
        sel_o.primary_sector_selects = (high_hit | ~pri_ok || ((|sec_hit) && sec_ok))
                                       ? '0 : pri_hit;
    end
endmodule

// ---- src/map_decode_params.svh ----
// offsets, field positions, reset values and timing counts for the map/decode block
`ifndef MAP_DECODE_PARAMS_SVH
`define MAP_DECODE_PARAMS_SVH

`define CFG_PAGE_OFFSET 8'hE0
`define CFG_MAP_OFFSET 8'hC2
`define CFG_PMODE0_OFFSET 8'hB0
`define CFG_PMODE2_OFFSET 8'hB4

`define MAP_PERIPHERAL_IO_ENABLE_BIT 7
`define MAP_PRI_DATA_BIT 4
`define MAP_SEC_DATA_BIT 3
`define MAP_PRI_CODE_BIT 2
`define MAP_SEC_CODE_BIT 1
`define MAP_RAM_CODE_BIT 0
`define MAP_USED_MASK 8'h9F
`define MAP_RESET 8'h0C
`define PAGE_RESET 8'h00
`define PMODE0_TURBO_BIT 3
`define PMODE0_RESET 8'h08
`define PMODE2_RESET 8'h00
`define PMODE2_MASK 8'h1F

`define IDLE_TIME_NS 70
`define CLK_PERIOD_NS 50
// least time, rounded up to whole cycles
`define IDLE_CYCLES ((`IDLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- src/map_decode_pkg.sv ----
// types for the memory map, page register and decode block
package map_decode_pkg;

    typedef struct packed {
        logic [19:0] addr;
        logic        wide_addr;
        logic        rd;
        logic        wr;
        logic        fetch;
        logic [7:0]  wdata;
    } host_bus_t;

    typedef struct packed {
        logic [7:0] primary_sector_selects;
        logic [3:0] secondary_sector_selects;
        logic       ram_select;
        logic       config_select;
        logic       jtag_select;
        logic [1:0] periph_selects;
    } selects_t;

    // one sector window: match when (addr & mask) == (base & mask)
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] mask;
    } window_t;

    typedef struct packed {
        logic [7:0] ports_a;
        logic [7:0] ports_b;
        logic [7:0] ports_c;
        logic [2:0] ports_d;
        logic [15:0] mcell_fb;
        logic       rdy_busy;
        logic       power_down_input;
    } array_misc_t;

endpackage

// ---- src/map_page_decode.sv ----
// memory map register, page register, power control and decode for the host bus
`include "map_decode_params.svh"

// What this block does
// - map bit 7 enables peripheral io mode
// - map bit 4 gates read access, primary
// - map bit 3 gates read access, secondary
// - map bit 2 gates fetch access, primary
// - map bit 1 gates fetch access, secondary
// - map bit 0 gates fetch access to sram
// - eight-bit page register extends address range
// - page register readable and writable on d7..d0
// - page register sits at config offset e0
// - page bits feed sector and sram decode
// - page bits also go to general logic
// - arrays idle after about 70ns unchanged
// - turbo bit clear allows automatic array standby
// - three bits block host strobes into arrays
// - seventy-three signal input bus to arrays
// - wide-address mode uses address bits 19..4
// - eight primary selects, three terms each
// - four secondary selects, three terms each
// - one sram select, one config select
// - jtag select enables test port
// - two peripheral selects for peripheral io mode
// - decode active right after reset, no setup
// - priority: ram/io over secondary over primary
// - sram enabled only while select high
module map_page_decode
    import map_decode_pkg::*;
#(
    parameter int N_PRI = 8,
    parameter int N_SEC = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // host bus pins
    input wire map_decode_pkg::host_bus_t bus_i,
    output logic [7:0] rdata_o,
    output logic rdata_oe_o,
    // other array inputs from pins
    input wire map_decode_pkg::array_misc_t misc_i,
    // decode programming
    input wire map_decode_pkg::window_t [N_PRI*3-1:0] pri_win_i,
    input wire map_decode_pkg::window_t [N_SEC*3-1:0] sec_win_i,
    input wire map_decode_pkg::window_t [1:0] ram_win_i,
    input wire map_decode_pkg::window_t cfg_win_i,
    input wire map_decode_pkg::window_t jtag_win_i,
    input wire map_decode_pkg::window_t [1:0] periph_win_i,
    input wire logic [7:0] page_match_i,
    // selects and array feeds
    output map_decode_pkg::selects_t sel_o,
    output logic [7:0] page_bits_o,
    output logic [72:0] array_input_bus_o,
    output logic array_standby_o,
    output logic peripheral_io_enable_o
);
    import map_decode_pkg::*;

    localparam int IDLE_W = 8;
    localparam logic [IDLE_W-1:0] IDLE_CNT = IDLE_W'(`IDLE_CYCLES);

    typedef struct packed {
        host_bus_t bus_s1;
        array_misc_t misc_s1;
        host_bus_t bus_s2;
        array_misc_t misc_s2;
        logic [7:0] map_live;
        logic [7:0] map_pend;
        logic [7:0] page_live;
        logic [7:0] page_pend;
        logic [7:0] pmode0;
        logic [7:0] pmode2;
        logic [72:0] bus_prev;
        logic [IDLE_W-1:0] idle_cnt;
        logic standby;
        selects_t sel;
        logic [7:0] rdata;
        logic rdata_oe;
        logic [72:0] ibus;
    } state_t;

    state_t state_q;
    state_t state_d;

    selects_t dec_sel;
    logic [15:0] pla_addr;
    logic [2:0] ctl_gated;
    logic any_strobe;
    logic cfg_hit_now;
    logic [7:0] cfg_off;
    logic [72:0] ibus_now;

    function automatic logic [15:0] pla_address(input host_bus_t b);
        pla_address = b.wide_addr ? b.addr[19:4] : b.addr[15:0];
    endfunction

    // ----------------------------------------
    // array address and strobe gating
    // ----------------------------------------
    assign pla_addr = pla_address(state_q.bus_s2);
    // power mode reg2 bits 0..2 block wr, rd, fetch into arrays
    assign ctl_gated = {state_q.bus_s2.fetch & ~state_q.pmode2[2],
                        state_q.bus_s2.rd & ~state_q.pmode2[1],
                        state_q.bus_s2.wr & ~state_q.pmode2[0]};
    assign any_strobe = state_q.bus_s2.rd | state_q.bus_s2.wr | state_q.bus_s2.fetch;
    assign cfg_off = state_q.bus_s2.addr[7:0];

    // ----------------------------------------
    // decode array
    // ----------------------------------------
    decode_array #(
        .N_PRI(N_PRI),
        .N_SEC(N_SEC)
    ) u_decode (
        .pla_addr_i(pla_addr),
        .page_bits_i(state_q.page_live),
        .map_i(state_q.map_live),
        .rd_i(state_q.bus_s2.rd),
        .fetch_i(state_q.bus_s2.fetch),
        .any_strobe_i(any_strobe),
        .pri_win_i(pri_win_i),
        .sec_win_i(sec_win_i),
        .ram_win_i(ram_win_i),
        .cfg_win_i(cfg_win_i),
        .jtag_win_i(jtag_win_i),
        .periph_win_i(periph_win_i),
        .page_match_i(page_match_i),
        .sel_o(dec_sel)
    );
    assign cfg_hit_now = dec_sel.config_select;

    // ----------------------------------------
    // array input bus, 73 signals
    // ----------------------------------------
    assign ibus_now = {pla_addr, ctl_gated, ~rst_n_i, state_q.misc_s2.power_down_input,
                       state_q.misc_s2.ports_a, state_q.misc_s2.ports_b,
                       state_q.misc_s2.ports_c, state_q.misc_s2.ports_d,
                       state_q.page_live, state_q.misc_s2.mcell_fb,
                       state_q.misc_s2.rdy_busy};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.bus_s1 = bus_i;
        state_d.misc_s1 = misc_i;
        state_d.bus_s2 = state_q.bus_s1;
        state_d.misc_s2 = state_q.misc_s1;
        // config space writes, map and page staged until the cycle ends
        if (cfg_hit_now && state_q.bus_s2.wr) begin
            if (cfg_off == `CFG_PAGE_OFFSET) begin
                state_d.page_pend = state_q.bus_s2.wdata;
            end else if (cfg_off == `CFG_MAP_OFFSET) begin
                state_d.map_pend = state_q.bus_s2.wdata & `MAP_USED_MASK;
            end else if (cfg_off == `CFG_PMODE0_OFFSET) begin
                state_d.pmode0 = state_q.bus_s2.wdata;
            end else if (cfg_off == `CFG_PMODE2_OFFSET) begin
                state_d.pmode2 = state_q.bus_s2.wdata & `PMODE2_MASK;
            end
        end
        // apply staged values only between strobes
        if (!any_strobe) begin
            state_d.map_live = state_q.map_pend;
            state_d.page_live = state_q.page_pend;
        end
        // config space reads
        state_d.rdata_oe = cfg_hit_now && state_q.bus_s2.rd;
        if (cfg_off == `CFG_PAGE_OFFSET) begin
            state_d.rdata = state_q.page_pend;
        end else if (cfg_off == `CFG_MAP_OFFSET) begin
            state_d.rdata = state_q.map_pend;
        end else if (cfg_off == `CFG_PMODE0_OFFSET) begin
            state_d.rdata = state_q.pmode0;
        end else if (cfg_off == `CFG_PMODE2_OFFSET) begin
            state_d.rdata = state_q.pmode2;
        end else begin
            state_d.rdata = 8'h00;
        end
        // standby: turbo off and inputs steady long enough
        state_d.bus_prev = ibus_now;
        if (ibus_now != state_q.bus_prev) begin
            state_d.idle_cnt = '0;
            state_d.standby = 1'b0;
        end else if (state_q.idle_cnt < IDLE_CNT) begin
            state_d.idle_cnt = state_q.idle_cnt + 1'b1;
        end else begin
            state_d.standby = ~state_q.pmode0[`PMODE0_TURBO_BIT];
        end
        state_d.sel = dec_sel;
        state_d.ibus = ibus_now;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
            state_q.map_live <= `MAP_RESET;
            state_q.map_pend <= `MAP_RESET;
            state_q.page_live <= `PAGE_RESET;
            state_q.page_pend <= `PAGE_RESET;
            state_q.pmode0 <= `PMODE0_RESET;
            state_q.pmode2 <= `PMODE2_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o = state_q.rdata;
    assign rdata_oe_o = state_q.rdata_oe;
    assign sel_o = state_q.sel;
    assign page_bits_o = state_q.page_live;
    assign array_input_bus_o = state_q.ibus;
    assign array_standby_o = state_q.standby;
    assign peripheral_io_enable_o = state_q.map_live[`MAP_PERIPHERAL_IO_ENABLE_BIT];
endmodule

// ---- test/host_bus_model.sv ----
// host controller model driving the multiplexed bus strobes
module host_bus_model
    import map_decode_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // host bus pins
    output map_decode_pkg::host_bus_t bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial bus_o = '0;
    // one strobe held until the caller releases it
    task automatic drive(input logic [19:0] a, input logic wa, w, r, f, input logic [7:0] d);
        @(negedge clk_sys_i);
        bus_o.addr = a;
        bus_o.wide_addr = wa;
        bus_o.wr = w;
        bus_o.rd = r;
        bus_o.fetch = f;
        bus_o.wdata = w ? d : ~bus_o.wdata;
    endtask
    // released data lines must not keep the last value
    task automatic idle();
        @(negedge clk_sys_i);
        bus_o.wr = 1'b0;
        bus_o.rd = 1'b0;
        bus_o.fetch = 1'b0;
        bus_o.wdata = ~bus_o.wdata;
        repeat (4) @(negedge clk_sys_i);
    endtask
endmodule

// ---- test/map_page_decode_props.sv ----
// assertion checker for the map, page and decode block
module map_page_decode_props
    import map_decode_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // watched ports
    input wire map_decode_pkg::host_bus_t bus_i,
    input wire logic rdata_oe_o,
    input wire map_decode_pkg::selects_t sel_o,
    input wire logic [7:0] page_bits_o,
    input wire logic [72:0] array_input_bus_o,
    input wire logic array_standby_o,
    input wire logic peripheral_io_enable_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    logic pri_any;
    logic sec_any;
    // cycles since reset release, until the sync pipeline holds live pins
    logic [1:0] since_rst_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            since_rst_q <= 2'h0;
        end else if (since_rst_q != 2'h3) begin
            since_rst_q <= since_rst_q + 2'h1;
        end
    end
    assign pri_any = |sel_o.primary_sector_selects;
    assign sec_any = |sel_o.secondary_sector_selects;
    sequence bus_moves;
        $changed(array_input_bus_o);
    endsequence
    sequence was_still;
        $past(array_input_bus_o, 1) == $past(array_input_bus_o, 2);
    endsequence
    standby_drop_a: assert property (bus_moves |=> !array_standby_o)
        else $error("standby held across input change");
    standby_wait_a: assert property ($rose(array_standby_o) |-> was_still)
        else $error("standby entered while inputs moved");
    reset_clear_a: assert property ($rose(rst_n_i) |-> sel_o == '0 && page_bits_o == 8'h00)
        else $error("selects or page not cleared by reset");
    sel_strobe_a: assert property ((pri_any || sec_any || sel_o.ram_select)
        |-> $past(bus_i.rd, 3) || $past(bus_i.fetch, 3))
        else $error("memory select without strobe");
    prio_order_a: assert property (!(sel_o.ram_select && (pri_any || sec_any))
        && !(sec_any && pri_any))
        else $error("overlapping selects both active");
    periph_mode_a: assert property (sel_o.periph_selects != 2'b00 |-> peripheral_io_enable_o)
        else $error("peripheral select outside peripheral mode");
    read_drive_a: assert property (rdata_oe_o |-> $past(bus_i.rd, 3))
        else $error("data driven without read");
    addr_feed_a: assert property (since_rst_q == 2'h3 |->
        array_input_bus_o[72:57] == ($past(bus_i.wide_addr, 3)
        ? $past(bus_i.addr[19:4], 3) : $past(bus_i.addr[15:0], 3)))
        else $error("array address bits wrong");
endmodule

bind map_page_decode map_page_decode_props u_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_oe_o(rdata_oe_o),
    .sel_o(sel_o), .page_bits_o(page_bits_o), .array_input_bus_o(array_input_bus_o),
    .array_standby_o(array_standby_o), .peripheral_io_enable_o(peripheral_io_enable_o)
);

// ---- test/tb.sv ----
// self-checking bench for the map, page and decode block
`include "map_decode_params.svh"
module tb import map_decode_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] map, page, pm;
        logic [19:0] a;
        logic wa, rd, f;
        logic [16:0] exp;
    } row_t;
    localparam window_t NONE = '{16'h0001, 16'hFFFF};
    logic clk_sys_i, rst_n_i, rdata_oe, standby, pio;
    host_bus_t bus;
    array_misc_t misc;
    window_t [23:0] pri_win;
    window_t [11:0] sec_win;
    window_t [1:0] ram_win, periph_win;
    window_t cfg_win, jtag_win;
    logic [7:0] page_match, rdata, page_bits;
    selects_t sel;
    logic [72:0] abus;
    int fail_count = 0;
    int total_checks = 0;
    row_t rows [17] = '{
        '{8'h0C, 8'h00, 8'h00, 20'h08000, 1'b0, 1'b1, 1'b0, 17'h00010},
        '{8'h0C, 8'h00, 8'h00, 20'h08800, 1'b0, 1'b1, 1'b0, 17'h00020},
        '{8'h00, 8'h00, 8'h00, 20'h08800, 1'b0, 1'b1, 1'b0, 17'h00000},
        '{8'h10, 8'h00, 8'h00, 20'h0A000, 1'b0, 1'b1, 1'b0, 17'h00200},
        '{8'h0C, 8'h00, 8'h00, 20'h0A000, 1'b0, 1'b1, 1'b0, 17'h00000},
        '{8'h04, 8'h00, 8'h00, 20'h0A000, 1'b0, 1'b0, 1'b1, 17'h00200},
        '{8'h08, 8'h00, 8'h00, 20'h0A000, 1'b0, 1'b0, 1'b1, 17'h00000},
        '{8'h02, 8'h00, 8'h00, 20'h08800, 1'b0, 1'b0, 1'b1, 17'h00020},
        '{8'h01, 8'h00, 8'h00, 20'h08000, 1'b0, 1'b0, 1'b1, 17'h00010},
        '{8'h00, 8'h00, 8'h00, 20'h08000, 1'b0, 1'b0, 1'b1, 17'h00000},
        '{8'h0C, 8'h5A, 8'h00, 20'h04000, 1'b0, 1'b1, 1'b0, 17'h00004},
        '{8'h80, 8'h00, 8'h00, 20'h05000, 1'b0, 1'b1, 1'b0, 17'h00001},
        '{8'h00, 8'h00, 8'h00, 20'h05000, 1'b0, 1'b1, 1'b0, 17'h00000},
        '{8'h0C, 8'h00, 8'h01, 20'h08000, 1'b0, 1'b1, 1'b0, 17'h00000},
        '{8'h0C, 8'h01, 8'h01, 20'h08000, 1'b0, 1'b1, 1'b0, 17'h00010},
        '{8'h0C, 8'h00, 8'h00, 20'h88000, 1'b1, 1'b1, 1'b0, 17'h00020},
        '{8'h0C, 8'h00, 8'h00, 20'h0FFE0, 1'b0, 1'b1, 1'b0, 17'h00008}};

    map_page_decode u_map_page_decode (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .rdata_o(rdata), .rdata_oe_o(rdata_oe), .misc_i(misc), .pri_win_i(pri_win),
        .sec_win_i(sec_win), .ram_win_i(ram_win), .cfg_win_i(cfg_win), .jtag_win_i(jtag_win),
        .periph_win_i(periph_win), .page_match_i(page_match), .sel_o(sel),
        .page_bits_o(page_bits), .array_input_bus_o(abus), .array_standby_o(standby),
        .peripheral_io_enable_o(pio));
    host_bus_model u_host_bus_model (.clk_sys_i(clk_sys_i), .bus_o(bus));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic acc(input logic [19:0] a, input logic wa, w, r, f, input logic [7:0] d);
        u_host_bus_model.drive(a, wa, w, r, f, d);
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic wr_reg(input logic [7:0] off, input logic [7:0] d);
        acc({12'h0FF, off}, 1'b0, 1'b1, 1'b0, 1'b0, d);
        u_host_bus_model.idle();
    endtask

    task automatic rd_reg(input logic [7:0] off, input logic [7:0] exp);
        acc({12'h0FF, off}, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        chk(rdata, exp);
        chk(rdata_oe, 1);
        u_host_bus_model.idle();
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        wrap_up();
    end

    initial begin
        rst_n_i = 1'b0;
        misc = '0;
        page_match = '0;
        pri_win = {24{NONE}};
        sec_win = {12{NONE}};
        ram_win = {2{NONE}};
        periph_win = {NONE, 32'h5000FFFF};
        cfg_win = '{16'hFF00, 16'hFF00};
        jtag_win = '{16'h4000, 16'hFFFF};
        pri_win[0] = '{16'h8000, 16'hC000};
        sec_win[0] = '{16'h8000, 16'hE000};
        ram_win[0] = '{16'h8000, 16'hF800};
        repeat (20) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk(sel, 0);
        rd_reg(`CFG_MAP_OFFSET, `MAP_RESET);
        rd_reg(`CFG_PAGE_OFFSET, 8'h00);
        foreach (rows[i]) begin
            wr_reg(`CFG_MAP_OFFSET, rows[i].map);
            wr_reg(`CFG_PAGE_OFFSET, rows[i].page);
            page_match = rows[i].pm;
            acc(rows[i].a, rows[i].wa, 1'b0, rows[i].rd, rows[i].f, 8'h00);
            chk(sel, rows[i].exp);
            chk(abus[72:57], rows[i].wa ? rows[i].a[19:4] : rows[i].a[15:0]);
            chk(page_bits, rows[i].page);
            chk(abus[24:17], rows[i].page);
            u_host_bus_model.idle();
        end
        page_match = 8'h00;
        wr_reg(`CFG_MAP_OFFSET, 8'hFF);
        rd_reg(`CFG_MAP_OFFSET, 8'h9F);
        chk(pio, 1);
        wr_reg(`CFG_PAGE_OFFSET, 8'hA5);
        rd_reg(`CFG_PAGE_OFFSET, 8'hA5);
        chk(page_bits, 8'hA5);
        rd_reg(8'hE1, 8'h00);
        wr_reg(`CFG_PMODE0_OFFSET, 8'h00);
        repeat (6) @(negedge clk_sys_i);
        chk(standby, 1);
        misc.ports_a = 8'h3C;
        repeat (4) @(negedge clk_sys_i);
        chk(standby, 0);
        wr_reg(`CFG_PMODE0_OFFSET, 8'h08);
        repeat (6) @(negedge clk_sys_i);
        chk(standby, 0);
        wr_reg(`CFG_PMODE2_OFFSET, 8'hFF);
        rd_reg(`CFG_PMODE2_OFFSET, `PMODE2_MASK);
        acc(20'h04000, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        chk(abus[54], 0);
        u_host_bus_model.idle();
        acc(20'h08000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
        chk(abus[56], 0);
        u_host_bus_model.idle();
        acc(20'h08000, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        chk(abus[55], 0);
        u_host_bus_model.idle();
        wr_reg(`CFG_PMODE2_OFFSET, 8'h00);
        acc(20'h08000, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        chk(abus[55], 1);
        u_host_bus_model.idle();
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk(page_bits, 8'h00);
        chk(pio, 0);
        wrap_up();
    end
endmodule
